// File: hdl/pmm_pkg.sv
// Purpose: Shared constants and types for the program memory map and mode select block.
// Assumes: AHB-Lite register access with 32-bit data, one word per register.
// Notes: All offsets are byte addresses.
package pmm_pkg;
  localparam int unsigned PC_W          = 21;
  localparam logic [20:0] RESET_VEC     = 21'h000000;
  localparam logic [20:0] HI_VEC        = 21'h000008;
  localparam logic [20:0] LO_VEC        = 21'h000018;
  localparam logic [20:0] CFG_BLK_BYTES = 21'h000008;
  localparam logic [7:0]  CFG_RST       = 8'hF8;
  localparam logic [7:0]  CFG_IMPL_MASK = 8'hF8;
  localparam int unsigned WAIT_BIT      = 7;
  localparam int unsigned WIDTH_BIT     = 6;
  localparam int unsigned MODE_HI       = 5;
  localparam int unsigned MODE_LO       = 4;
  localparam int unsigned SHIFT_BIT     = 3;
  localparam logic [11:0] OFF_CFG       = 12'h000;
  localparam logic [11:0] OFF_STAT      = 12'h004;
  localparam logic [11:0] OFF_WAITCNT   = 12'h008;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    MODE_EXT20  = 2'b00,
    MODE_EXT16  = 2'b01,
    MODE_EXT12  = 2'b10,
    MODE_ONCHIP = 2'b11
  } pmm_mode_e;

  typedef struct packed {
    logic        ext_sel;
    logic [20:0] ext_addr;
    logic [20:0] int_addr;
  } pmm_route_s;
endpackage : pmm_pkg

// File: hdl/pmm_top.sv
// Purpose: Program memory map, fetch routing and external bus configuration byte.
// Assumes: Configuration words are read from flash by this block after reset.
// Notes: Bus registers answer with zero wait states.
`timescale 1ns/1ps
module pmm_top
  import pmm_pkg::*;
#(
  parameter logic [20:0] ONCHIP_SIZE = 21'h020000,
  parameter bit          PKG_80PIN   = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        fetch_req,
  input  wire logic        pc_load,
  input  wire logic [20:0] pc_load_val,
  input  wire logic        vec_hi,
  input  wire logic        vec_lo,
  output logic [20:0]      pc,
  output logic             flash_rd,
  output logic [20:0]      flash_addr,
  input  wire logic [7:0]  flash_data,
  input  wire logic [15:0] int_rdata,
  input  wire logic [15:0] ext_rdata,
  output logic [15:0]      fetch_data,
  output logic             ext_sel,
  output logic [20:0]      ext_addr,
  output logic [20:0]      int_addr,
  output logic             ext_bus_en,
  output logic             ext_wide,
  output logic             ext_wait_en,
  output logic [1:0]       ext_wait_cnt,
  output logic             cfg_ready,
  output logic             data_ram_en
);
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN  = 2'b01
  } pmm_state_e;

  function automatic logic [4:0] addr_bits(input logic [1:0] m);
    unique case (m)
      MODE_EXT12: addr_bits = 5'd12;
      MODE_EXT16: addr_bits = 5'd16;
      default:    addr_bits = 5'd20;
    endcase
  endfunction : addr_bits

  // Small package parts have none of the option bits, so they always read as zero.
  function automatic logic [7:0] cfg_view(input logic [7:0] c);
    cfg_view = PKG_80PIN ? (c & CFG_IMPL_MASK) : 8'h00;
  endfunction : cfg_view

  localparam logic [20:0] CFG_BASE = ONCHIP_SIZE - CFG_BLK_BYTES;

  pmm_state_e  st_q, st_d;
  logic [2:0]  idx_q, idx_d;
  logic [7:0]  cfg_q, cfg_d;
  logic        wo_q, wo_d;
  logic [1:0]  wcnt_q, wcnt_d;
  logic [20:0] pc_q, pc_d;
  logic        wr_q, wr_d;
  logic [11:0] wa_q, wa_d;
  logic        rd_q, rd_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0]  cfg_eff;
  logic [1:0]  mode;
  logic        onchip;
  logic [20:0] raw, mask;
  pmm_route_s  rt;

  // The mode and option bits are absent on the small package.
  assign cfg_eff = cfg_view(cfg_q);
  assign mode    = PKG_80PIN ? cfg_eff[MODE_HI:MODE_LO] : MODE_ONCHIP;
  assign onchip  = (mode == MODE_ONCHIP);

  // Configuration byte sits at block offset 4 (third word, low byte); word four is skipped.
  always_comb begin
    st_d  = st_q;
    idx_d = idx_q;
    cfg_d = cfg_q;
    wo_d  = wo_q;
    if (st_q == ST_LOAD) begin
      idx_d = idx_q + 3'd1;
      if (idx_q == 3'd4) begin
        cfg_d = flash_data & CFG_IMPL_MASK;
      end
      if (idx_q == 3'd5) begin
        st_d = ST_RUN;
      end
    end else if (wr_q && wa_q == OFF_CFG && !wo_q) begin
      cfg_d = hwdata[7:0] & CFG_IMPL_MASK;
      wo_d  = 1'b1;
    end
  end

  assign flash_rd   = (st_q == ST_LOAD);
  assign flash_addr = CFG_BASE + {18'h0, idx_q};
  assign cfg_ready  = (st_q == ST_RUN);

  always_comb begin
    pc_d = pc_q;
    if (st_q == ST_RUN) begin
      if (vec_hi) begin
        pc_d = HI_VEC;
      end else if (vec_lo) begin
        pc_d = LO_VEC;
      end else if (pc_load) begin
        pc_d = {pc_load_val[20:1], 1'b0};
      end else if (fetch_req) begin
        pc_d = pc_q + 21'h000002;
      end
    end
  end

  always_comb begin
    raw         = pc_q - ONCHIP_SIZE;
    mask        = 21'h1FFFFF >> (5'd21 - addr_bits(mode));
    rt.ext_sel  = !onchip && (pc_q >= ONCHIP_SIZE);
    rt.int_addr = pc_q;
    rt.ext_addr = 21'h000000;
    if (rt.ext_sel) begin
      rt.ext_addr = (cfg_eff[SHIFT_BIT] ? raw : pc_q) & mask;
    end
  end

  always_comb begin
    if (rt.ext_sel) begin
      fetch_data = ext_rdata;
    end else if (pc_q < ONCHIP_SIZE) begin
      fetch_data = int_rdata;
    end else begin
      fetch_data = 16'h0000;
    end
  end

  assign pc           = pc_q;
  assign ext_sel      = rt.ext_sel;
  assign ext_addr     = rt.ext_addr;
  assign int_addr     = rt.int_addr;
  assign ext_bus_en   = !onchip;
  assign ext_wide     = cfg_eff[WIDTH_BIT];
  assign ext_wait_en  = !onchip && !cfg_eff[WAIT_BIT];
  assign ext_wait_cnt = ext_wait_en ? wcnt_q : 2'h0;
  assign data_ram_en  = 1'b1;

  // AHB-Lite slave, zero wait states, always OKAY.
  always_comb begin
    wr_d   = 1'b0;
    rd_d   = 1'b0;
    wa_d   = wa_q;
    wcnt_d = wcnt_q;
    rdat_d = rdat_q;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      wr_d = hwrite;
      rd_d = !hwrite;
      wa_d = haddr[11:0];
    end
    if (wr_q && wa_q == OFF_WAITCNT) begin
      wcnt_d = hwdata[5:4];
    end
    // Config byte, write-once flag and wait count come from next-state values so a read right behind a write sees the new value.
    if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
      unique case (haddr[11:0])
        OFF_CFG:     rdat_d = {24'h0, cfg_view(cfg_d)};
        OFF_STAT:    rdat_d = {27'h0, rt.ext_sel, onchip, wo_d, cfg_ready, 1'b0};
        OFF_WAITCNT: rdat_d = {26'h0, wcnt_d, 4'h0};
        default:     rdat_d = 32'h00000000;
      endcase
    end
  end

  assign hrdata    = rdat_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= ST_LOAD;
      idx_q  <= 3'h0;
      cfg_q  <= CFG_RST;
      wo_q   <= 1'b0;
      wcnt_q <= 2'h0;
      pc_q   <= RESET_VEC;
      wr_q   <= 1'b0;
      wa_q   <= 12'h000;
      rd_q   <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      cfg_q  <= cfg_d;
      wo_q   <= wo_d;
      wcnt_q <= wcnt_d;
      pc_q   <= pc_d;
      wr_q   <= wr_d;
      wa_q   <= wa_d;
      rd_q   <= rd_d;
      rdat_q <= rdat_d;
    end
  end

  property p_reset_vec;
    @(posedge clk) $fell(rst) |-> pc_q == RESET_VEC;
  endproperty
  reset_vector_a: assert property (p_reset_vec) else $error("pc not at reset vector");

  hi_vector_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ready && vec_hi |=> pc_q == HI_VEC) else $error("high vector wrong");
  lo_vector_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ready && !vec_hi && vec_lo |=> pc_q == LO_VEC) else $error("low vector wrong");
  pc_step_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ready && fetch_req && !vec_hi && !vec_lo && !pc_load |=> pc_q == $past(pc_q) + 21'h000002)
    else $error("pc did not step by two");

  sequence s_load;
    !cfg_ready [*6];
  endsequence
  cfg_load_a: assert property (@(posedge clk) $fell(rst) |-> s_load ##1 cfg_ready)
    else $error("config load length wrong");

  onchip_route_a: assert property (@(posedge clk) disable iff (rst)
    onchip |-> !ext_sel && ext_addr == 21'h000000) else $error("external access in on-chip mode");
  zero_read_a: assert property (@(posedge clk) disable iff (rst)
    pc_q >= ONCHIP_SIZE && onchip |-> fetch_data == 16'h0000) else $error("unimplemented read not zero");
  ext_route_a: assert property (@(posedge clk) disable iff (rst)
    !onchip && pc_q >= ONCHIP_SIZE |-> ext_sel) else $error("fetch not routed externally");
  addr_shift_a: assert property (@(posedge clk) disable iff (rst)
    ext_sel && cfg_eff[SHIFT_BIT] && mode == MODE_EXT20 |-> ext_addr == ((pc_q - ONCHIP_SIZE) & 21'h0FFFFF))
    else $error("shifted address wrong");
  width_mask_a: assert property (@(posedge clk) disable iff (rst)
    mode == MODE_EXT12 |-> ext_addr[20:12] == 9'h000) else $error("upper address bits active");
  write_once_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ready && wo_q |=> cfg_q == $past(cfg_q)) else $error("config byte rewritten");
  wait_gate_a: assert property (@(posedge clk) disable iff (rst)
    cfg_eff[WAIT_BIT] |-> !ext_wait_en && ext_wait_cnt == 2'h0) else $error("wait states not disabled");

  read_cfg_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ready && rd_q && wa_q == OFF_CFG |-> hrdata == {24'h0, cfg_eff})
    else $error("config read data wrong");
  unimpl_zero_a: assert property (@(posedge clk) disable iff (rst)
    rd_q && wa_q == OFF_CFG |-> hrdata[2:0] == 3'h0)
    else $error("unimplemented config bits not zero");
  small_pkg_a: assert property (@(posedge clk) disable iff (rst)
    !PKG_80PIN |-> onchip && !ext_bus_en)
    else $error("extended mode on small package");
  pkg_bits_a: assert property (@(posedge clk) disable iff (rst)
    !PKG_80PIN |-> cfg_eff == 8'h00)
    else $error("option bits present on small package");
  ext_bus_a: assert property (@(posedge clk) disable iff (rst)
    cfg_eff[MODE_HI:MODE_LO] == 2'b11 |-> !ext_bus_en && !ext_wait_en)
    else $error("external bus active in on-chip mode");
  data_width_a: assert property (@(posedge clk) disable iff (rst)
    ext_wide == cfg_eff[WIDTH_BIT])
    else $error("data width select wrong");
  wait_count_a: assert property (@(posedge clk) disable iff (rst)
    ext_wait_en |-> ext_wait_cnt == wcnt_q)
    else $error("wait count not passed on");
  no_shift_a: assert property (@(posedge clk) disable iff (rst)
    ext_sel && !cfg_eff[SHIFT_BIT] && mode == MODE_EXT16 |-> ext_addr == (pc_q & 21'h00FFFF))
    else $error("unshifted address wrong");
  mask_sixteen_a: assert property (@(posedge clk) disable iff (rst)
    mode == MODE_EXT16 |-> ext_addr[20:16] == 5'h00)
    else $error("upper address bits active in 16-bit mode");
  flash_read_a: assert property (@(posedge clk) disable iff (rst)
    flash_rd == !cfg_ready)
    else $error("flash read outside config load");
  pc_hold_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_ready |-> pc_q == RESET_VEC)
    else $error("pc left reset vector during load");
  pc_align_a: assert property (@(posedge clk) disable iff (rst)
    pc_q[0] == 1'b0)
    else $error("pc not word aligned");
  ram_open_a: assert property (@(posedge clk) disable iff (rst)
    data_ram_en)
    else $error("data ram bus closed");
  int_fetch_a: assert property (@(posedge clk) disable iff (rst)
    pc_q < ONCHIP_SIZE |-> !ext_sel && fetch_data == int_rdata)
    else $error("internal fetch misrouted");
  ext_fetch_a: assert property (@(posedge clk) disable iff (rst)
    ext_sel |-> fetch_data == ext_rdata)
    else $error("external fetch data misrouted");
endmodule : pmm_top

// File: test/pmm_mem_model.sv
// Purpose: Flash and program memory partner for the fetch router.
// Assumes: Combinational flash, one byte per address.
// Notes: Only the config low byte matters; other flash bytes read as ones.
`timescale 1ns/1ps
module pmm_mem_model
  import pmm_pkg::*;
#(
  parameter logic [20:0] ONCHIP_SIZE = 21'h001000,
  parameter logic [7:0]  CFG_BYTE    = 8'h08
) (
  input  wire logic [20:0] flash_addr,
  output logic [7:0]       flash_data,
  input  wire logic [20:0] int_addr,
  output logic [15:0]      int_rdata,
  input  wire logic [20:0] ext_addr,
  output logic [15:0]      ext_rdata
);
  // Low byte of word three sits at offset four of the top eight bytes.
  assign flash_data = (flash_addr == ONCHIP_SIZE - 21'h000004) ? CFG_BYTE : 8'hFF;
  // Distinct patterns so a wrong memory select shows in fetch data.
  assign int_rdata  = int_addr[15:0] ^ 16'hA5A5;
  assign ext_rdata  = ext_addr[15:0] ^ 16'h5A5A;
endmodule : pmm_mem_model

// File: test/pmm_top_tb.sv
// Purpose: Self-checking bench for program memory map and mode select.
// Assumes: Flash holds config byte 08h, so extended 20-bit mode with shift.
// Notes: A small on-chip size keeps addresses short.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; $display("BAD t=%0t %h %h", $time, (a), (b)); end end
module pmm_top_tb
  import pmm_pkg::*;
;
  localparam logic [20:0] SZ = 21'h001000;
  logic        clk, rst, hsel, hwrite, fetch_req, pc_load, vec_hi, vec_lo;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [20:0] pc_load_val, pc, flash_addr, ext_addr, int_addr;
  logic [7:0]  flash_data;
  logic [15:0] int_rdata, ext_rdata, fetch_data;
  logic        hreadyout, hresp, flash_rd, ext_sel, ext_bus_en, ext_wide, ext_wait_en, cfg_ready, data_ram_en;
  logic [1:0]  ext_wait_cnt;
  int          n_mismatch = 0;
  int          compares = 0;

  pmm_top #(.ONCHIP_SIZE(SZ), .PKG_80PIN(1'b1)) pmm_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fetch_req(fetch_req), .pc_load(pc_load), .pc_load_val(pc_load_val),
    .vec_hi(vec_hi), .vec_lo(vec_lo), .pc(pc), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_data(flash_data), .int_rdata(int_rdata), .ext_rdata(ext_rdata), .fetch_data(fetch_data),
    .ext_sel(ext_sel), .ext_addr(ext_addr), .int_addr(int_addr), .ext_bus_en(ext_bus_en), .ext_wide(ext_wide),
    .ext_wait_en(ext_wait_en), .ext_wait_cnt(ext_wait_cnt), .cfg_ready(cfg_ready), .data_ram_en(data_ram_en));
  pmm_mem_model #(.ONCHIP_SIZE(SZ), .CFG_BYTE(8'h08)) pmm_mem_model_i (.flash_addr(flash_addr),
    .flash_data(flash_data), .int_addr(int_addr), .int_rdata(int_rdata), .ext_addr(ext_addr),
    .ext_rdata(ext_rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // Waits for an edge with hready high; a hung slave ends the run.
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
  endtask : wait_rdy

  // Waits for the configuration load to finish; a stuck load ends the run.
  task automatic wait_cfg;
    int n;
    for (n = 0; n < 50 && cfg_ready !== 1'b1; n++) @(posedge clk);
    if (n >= 50) begin
      n_mismatch++;
      finish_test();
    end
  endtask : wait_cfg

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask : bus

  // Drives the load at a rising edge and returns once the new pc has settled.
  task automatic load_pc(input logic [20:0] a);
    @(posedge clk);
    pc_load <= 1'b1;
    pc_load_val <= a;
    @(posedge clk);
    pc_load <= 1'b0;
    #1;
  endtask : load_pc

  task automatic t_load;
    wait_cfg();
    `CHK({pc, data_ram_en}, {RESET_VEC, 1'b1})
    bus(1'b0, {20'h0, OFF_CFG}, 32'h0, rd);
    `CHK(rd, 32'h00000008)
    `CHK({ext_bus_en, ext_wait_en, ext_wide}, 3'b110)
    bus(1'b1, {20'h0, OFF_WAITCNT}, 32'h00000030, rd);
    bus(1'b0, {20'h0, OFF_WAITCNT}, 32'h0, rd);
    `CHK(rd, 32'h00000030)
    `CHK(ext_wait_cnt, 2'h3)
    bus(1'b0, 32'h00000010, 32'h0, rd);
    `CHK(rd, 32'h0)
  endtask : t_load

  task automatic t_fetch_vec;
    fetch_req <= 1'b1;
    repeat (3) @(posedge clk);
    fetch_req <= 1'b0;
    @(posedge clk);
    vec_lo <= 1'b1;
    vec_hi <= 1'b1;
    #1;
    `CHK(pc, 21'h000006)
    @(posedge clk);
    vec_hi <= 1'b0;
    #1;
    `CHK(pc, HI_VEC)
    @(posedge clk);
    vec_lo <= 1'b0;
    #1;
    `CHK(pc, LO_VEC)
  endtask : t_fetch_vec

  task automatic t_route;
    load_pc(21'h1FF006);
    `CHK(ext_sel, 1'b1)
    `CHK(ext_addr, 21'h0FE006)
    `CHK(fetch_data, 16'hE006 ^ 16'h5A5A)
    load_pc(21'h000100);
    `CHK({ext_sel, int_addr}, {1'b0, 21'h000100})
    `CHK(fetch_data, 16'h0100 ^ 16'hA5A5)
  endtask : t_route

  task automatic t_write_once;
    @(posedge clk);
    bus(1'b1, {20'h0, OFF_CFG}, 32'h000000D7, rd);
    `CHK({hresp, hreadyout}, 2'b01)
    bus(1'b1, {20'h0, OFF_CFG}, 32'h00000000, rd);
    bus(1'b0, {20'h0, OFF_CFG}, 32'h0, rd);
    `CHK(rd, 32'h000000D0)
    `CHK({ext_bus_en, ext_wait_en, ext_wide, ext_wait_cnt}, 5'b10100)
    load_pc(21'h1F1006);
    `CHK(ext_addr, 21'h001006)
  endtask : t_write_once

  // A second reset reloads flash and clears the write-once flag, so on-chip mode can be chosen.
  task automatic t_onchip;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({flash_rd, cfg_ready, ext_bus_en, pc}, {1'b1, 1'b0, 1'b0, RESET_VEC})
    rst <= 1'b0;
    wait_cfg();
    bus(1'b0, {20'h0, OFF_CFG}, 32'h0, rd);
    `CHK(rd, 32'h00000008)
    bus(1'b1, {20'h0, OFF_CFG}, 32'h00000038, rd);
    bus(1'b0, {20'h0, OFF_CFG}, 32'h0, rd);
    `CHK(rd, 32'h00000038)
    load_pc(21'h001100);
    `CHK({ext_sel, ext_bus_en, ext_addr, fetch_data}, {1'b0, 1'b0, 21'h000000, 16'h0000})
    load_pc(21'h000200);
    `CHK(fetch_data, 16'h0200 ^ 16'hA5A5)
  endtask : t_onchip

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fetch_req = 1'b0;
    pc_load = 1'b0;
    pc_load_val = 21'h0;
    vec_hi = 1'b0;
    vec_lo = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_load();
    t_fetch_vec();
    t_route();
    t_write_once();
    t_onchip();
    finish_test();
  end
endmodule : pmm_top_tb
